// >>> core/cqm_pair_filter.sv
`timescale 1ns/100ps
`default_nettype none
module cqm_pair_filter
    import cqm_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic RESET_N,
    input wire cqm_filt_cfg_s cfg,
    input wire logic sample_valid,
    input wire logic signed [CQM_ERR_W-1:0] sample_err,
    input wire logic period_end,
    output logic [CQM_ACC_W-1:0] mean_acc,
    output logic [CQM_ACC_W-1:0] peak_hold
);

    typedef struct packed {
        logic [CQM_ACC_W-1:0] mean;
        logic [CQM_ACC_W-1:0] peak;
        logic [CQM_ACC_W-1:0] period_max;
        logic [CQM_ACC_W-1:0] peak_save;
    } cqm_pf_state_s;

    cqm_pf_state_s st_q, st_d;
    logic [CQM_ERR_W-1:0] mag;
    logic [CQM_ERR_W:0] scaled;
    logic [CQM_ACC_W-1:0] target;
    logic signed [CQM_ACC_W:0] diff_m, diff_p;

    always_comb begin
        st_d = st_q;
        mag = sample_err[CQM_ERR_W-1] ? CQM_ERR_W'(-sample_err) : CQM_ERR_W'(sample_err);
        scaled = cfg.gigabit ? {mag, 1'b0} : {1'b0, mag};
        // Fixed-point target so small steps are not lost at large shifts
        if (cfg.square) begin
            target = CQM_ACC_W'(scaled * scaled) << CQM_FRAC_W;
        end else begin
            target = CQM_ACC_W'(scaled) << CQM_FRAC_W;
        end
        diff_m = $signed({1'b0, target}) - $signed({1'b0, st_q.mean});
        diff_p = $signed({1'b0, target}) - $signed({1'b0, st_q.peak});
        if (cfg.enable && sample_valid) begin
            st_d.mean = CQM_ACC_W'($signed({1'b0, st_q.mean}) + (diff_m >>> cfg.mean_shift));
            st_d.peak = CQM_ACC_W'($signed({1'b0, st_q.peak}) + (diff_p >>> cfg.peak_shift));
            if (st_d.peak > st_q.period_max) begin
                st_d.period_max = st_d.peak;
            end
        end
        if (period_end) begin
            st_d.peak_save = st_q.period_max;
            // A sample in the closing cycle already belongs to the next period
            st_d.period_max = (cfg.enable && sample_valid) ? st_d.peak : '0;
        end
        if (!cfg.enable) begin
            st_d = '0;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign mean_acc = st_q.mean;
    assign peak_hold = st_q.peak_save;

endmodule
`default_nettype wire

// >>> core/cqm_pkg.sv
package cqm_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] CQM_OFS_CONFIG = 8'h00;
    localparam logic [7:0] CQM_OFS_MEAN = 8'h04;
    localparam logic [7:0] CQM_OFS_MEAN_WORST = 8'h08;
    localparam logic [7:0] CQM_OFS_QUALITY = 8'h0C;
    localparam logic [7:0] CQM_OFS_SLICER_MEAN = 8'h10;
    localparam logic [7:0] CQM_OFS_PEAK = 8'h14;
    localparam logic [7:0] CQM_OFS_THRESH_LO = 8'h18;
    localparam logic [7:0] CQM_OFS_THRESH_HI = 8'h1C;
    localparam logic [7:0] CQM_OFS_THRESH_TOP = 8'h20;

    // ------------------------------------------------------------
    // Config, quality and peak register field positions
    // ------------------------------------------------------------
    localparam int CQM_CFG_ENABLE_BIT = 0;
    localparam int CQM_CFG_SQUARE_BIT = 1;
    localparam int CQM_CFG_GIGABIT_BIT = 2;
    localparam int CQM_CFG_CAPTURE_BIT = 3;
    localparam int CQM_CFG_PAIR_LSB = 4;
    localparam int CQM_CFG_MEAN_SHIFT_LSB = 8;
    localparam int CQM_CFG_PEAK_SHIFT_LSB = 12;
    localparam int CQM_CFG_MEAN_SCALE_LSB = 16;
    localparam int CQM_CFG_PEAK_SCALE_LSB = 21;
    localparam int CQM_QUAL_WORST_LSB = 4;
    localparam int CQM_PEAK_WORST_LSB = 8;

    // ------------------------------------------------------------
    // Widths and counts
    // ------------------------------------------------------------
    localparam int CQM_PAIRS = 4;
    localparam int CQM_ERR_W = 8;
    localparam int CQM_SHIFT_W = 4;
    localparam int CQM_SCALE_W = 5;
    localparam int CQM_FRAC_W = 15;
    localparam int CQM_ACC_W = 12 + CQM_FRAC_W + 1;
    localparam int CQM_MEAN_W = 9;
    localparam int CQM_PEAK_W = 6;
    localparam logic [CQM_MEAN_W-1:0] CQM_MEAN_MAX = 9'h1FF;
    localparam logic [CQM_PEAK_W-1:0] CQM_PEAK_MAX = 6'h3F;
    localparam int CQM_PEAK_EXTRA_SHIFT = 3;
    localparam int CQM_THRESH_COUNT = 7;
    localparam real CQM_SAVE_PERIOD_MS = 1.0;
    localparam real CQM_SYMBOL_RATE_HZ = 125.0e6;
    localparam int CQM_SAVE_SYMBOLS = int'(CQM_SAVE_PERIOD_MS * CQM_SYMBOL_RATE_HZ / 1000.0);
    localparam logic [31:0] CQM_CFG_RESET = 32'h0000_0000;
    localparam logic [CQM_MEAN_W-1:0] CQM_THRESH_RESET = 9'h000;

    typedef struct packed {
        logic valid;
        logic [1:0] pair;
        logic signed [CQM_ERR_W-1:0] err;
    } cqm_sample_s;

    typedef struct packed {
        logic enable;
        logic square;
        logic gigabit;
        logic [CQM_SHIFT_W-1:0] mean_shift;
        logic [CQM_SHIFT_W-1:0] peak_shift;
    } cqm_filt_cfg_s;

endpackage

// >>> core/cqm_top.sv
// ------------------------------------------------------------
// Overview of operation
// - Each symbol adds difference of error magnitude and filtered value; doubled at gigabit.
// - Mean add-back difference is divided by two to the mean filter shift.
// - Square mode squares the scaled error before filtering.
// - Mean-square result is filtered value over two to mean scale shift, saturating 511.
// - Capture bit write loads results for chosen pair and self-clears at once.
// - Filtered mean saved every 125000 symbols; capture returns latest saved value.
// - Worst-case register holds highest mean-square since last mean result read.
// - Seven thresholds map scaled mean-square onto quality index 0 to 7.
// - Capture places the pair's current quality index in quality result register.
// - Worst-case field holds lowest quality index since last quality read.
// - With square mode clear the absolute error is filtered instead.
// - Capture places latest saved filtered error in mean slicer error register.
// - Peak filter add-back is divided by two to the peak filter shift.
// - Each 1 ms period end saves the highest peak filter output.
// - Saved peak over two to peak scale shift plus three, saturating 63.
// - Capture loads peak result with scaled peak of selected pair.
// - Peak result also holds worst peak since that register was read.
// - Input error magnitude is at most 32 gigabit, 64 at 100 Mb/s.
// ------------------------------------------------------------
`timescale 1ns/100ps
`default_nettype none
module cqm_top
    import cqm_pkg::*;
#(
    parameter int SAVE_SYMBOLS = CQM_SAVE_SYMBOLS
)
(
    input wire logic SYS_CLK,
    input wire logic RESET_N,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire cqm_sample_s SAMPLE
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic bus_wr;
        logic bus_rd;
        logic [7:0] bus_addr;
        logic [31:0] rdata;
        logic [31:0] cfg;
        logic [CQM_THRESH_COUNT*CQM_MEAN_W-1:0] thresh;
        logic [16:0] sym_cnt;
        logic period_end;
        logic [CQM_PAIRS*CQM_ACC_W-1:0] mean_save;
        logic [CQM_MEAN_W-1:0] mean_res;
        logic [CQM_MEAN_W-1:0] mean_worst;
        logic [CQM_ACC_W-1:0] slicer_res;
        logic [2:0] qual_res;
        logic [2:0] qual_worst;
        logic [CQM_PEAK_W-1:0] peak_res;
        logic [CQM_PEAK_W-1:0] peak_worst;
    } cqm_state_s;

    cqm_state_s st_q, st_d;
    cqm_filt_cfg_s fcfg;
    logic [CQM_ACC_W-1:0] mean_acc [CQM_PAIRS];
    logic [CQM_ACC_W-1:0] peak_hold [CQM_PAIRS];
    logic [1:0] sel;
    logic [CQM_ACC_W-1:0] sel_mean_raw, sel_mean, sel_peak, sel_peak_int;
    logic [CQM_MEAN_W-1:0] mean_scaled;
    logic [CQM_PEAK_W-1:0] peak_scaled;
    logic [2:0] qual_now;
    logic [CQM_SCALE_W-1:0] mean_scale, peak_scale;
    logic bus_go;

    assign fcfg.enable = st_q.cfg[CQM_CFG_ENABLE_BIT];
    assign fcfg.square = st_q.cfg[CQM_CFG_SQUARE_BIT];
    assign fcfg.gigabit = st_q.cfg[CQM_CFG_GIGABIT_BIT];
    assign fcfg.mean_shift = st_q.cfg[CQM_CFG_MEAN_SHIFT_LSB +: CQM_SHIFT_W];
    assign fcfg.peak_shift = st_q.cfg[CQM_CFG_PEAK_SHIFT_LSB +: CQM_SHIFT_W];
    assign mean_scale = st_q.cfg[CQM_CFG_MEAN_SCALE_LSB +: CQM_SCALE_W];
    assign peak_scale = st_q.cfg[CQM_CFG_PEAK_SCALE_LSB +: CQM_SCALE_W];

    // ------------------------------------------------------------
    // Per-pair filters
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < CQM_PAIRS; gi++) begin : g_pair
            cqm_pair_filter u_filt (
                .SYS_CLK(SYS_CLK),
                .RESET_N(RESET_N),
                .cfg(fcfg),
                .sample_valid(SAMPLE.valid && (SAMPLE.pair == 2'(gi))),
                .sample_err(SAMPLE.err),
                .period_end(st_q.period_end),
                .mean_acc(mean_acc[gi]),
                .peak_hold(peak_hold[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Scaling and quality mapping of the selected pair
    // ------------------------------------------------------------
    always_comb begin
        sel = st_q.cfg[CQM_CFG_PAIR_LSB +: 2];
        sel_mean = st_q.mean_save[sel*CQM_ACC_W +: CQM_ACC_W];
        sel_mean_raw = sel_mean >> CQM_FRAC_W;
        sel_peak_int = peak_hold[sel] >> CQM_FRAC_W;
        // One bit wider so the largest scale plus three does not wrap
        sel_peak = sel_peak_int >> ({1'b0, peak_scale} + 6'(CQM_PEAK_EXTRA_SHIFT));
        peak_scaled = (sel_peak > CQM_ACC_W'(CQM_PEAK_MAX)) ? CQM_PEAK_MAX : sel_peak[CQM_PEAK_W-1:0];
        if ((sel_mean_raw >> mean_scale) > CQM_ACC_W'(CQM_MEAN_MAX)) begin
            mean_scaled = CQM_MEAN_MAX;
        end else begin
            mean_scaled = CQM_MEAN_W'(sel_mean_raw >> mean_scale);
        end
        // Thresholds are walked from best to worst; the last one exceeded sets the index
        qual_now = 3'h7;
        for (int k = CQM_THRESH_COUNT; k >= 1; k--) begin
            if (mean_scaled > st_q.thresh[(k-1)*CQM_MEAN_W +: CQM_MEAN_W]) begin
                qual_now = 3'(k - 1);
            end
        end
    end

    assign bus_go = HSEL && HREADY && HTRANS[1];

    // ------------------------------------------------------------
    // Bus slave and result registers
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        st_d.bus_wr = bus_go && HWRITE;
        st_d.bus_rd = bus_go && !HWRITE;
        if (bus_go) begin
            st_d.bus_addr = HADDR[7:0];
        end
        st_d.cfg[CQM_CFG_CAPTURE_BIT] = 1'b0;

        st_d.period_end = 1'b0;
        if (fcfg.enable) begin
            if (SAMPLE.valid) begin
                if (st_q.sym_cnt == 17'(SAVE_SYMBOLS - 1)) begin
                    st_d.sym_cnt = '0;
                    st_d.period_end = 1'b1;
                end else begin
                    st_d.sym_cnt = st_q.sym_cnt + 17'h1;
                end
            end
        end else begin
            st_d.sym_cnt = '0;
        end
        for (int p = 0; p < CQM_PAIRS; p++) begin
            if (st_q.period_end) begin
                st_d.mean_save[p*CQM_ACC_W +: CQM_ACC_W] = mean_acc[p];
            end
        end
        if (!fcfg.enable) begin
            st_d.mean_save = '0;
        end

        // Worst trackers follow the latched results; read reloads below
        if (st_q.bus_rd && st_q.bus_addr == CQM_OFS_MEAN) begin
            st_d.mean_worst = st_q.mean_res;
        end
        if (st_q.bus_rd && st_q.bus_addr == CQM_OFS_QUALITY) begin
            st_d.qual_worst = st_q.qual_res;
        end
        if (st_q.bus_rd && st_q.bus_addr == CQM_OFS_PEAK) begin
            st_d.peak_worst = st_q.peak_res;
        end

        if (st_q.bus_wr) begin
            case (st_q.bus_addr)
                CQM_OFS_CONFIG: begin
                    st_d.cfg = HWDATA;
                end
                CQM_OFS_THRESH_LO: begin
                    st_d.thresh[0 +: 3*CQM_MEAN_W] = HWDATA[3*CQM_MEAN_W-1:0];
                end
                // Seven 9-bit thresholds need three words
                CQM_OFS_THRESH_HI: begin
                    st_d.thresh[3*CQM_MEAN_W +: 3*CQM_MEAN_W] = HWDATA[3*CQM_MEAN_W-1:0];
                end
                CQM_OFS_THRESH_TOP: begin
                    st_d.thresh[6*CQM_MEAN_W +: CQM_MEAN_W] = HWDATA[CQM_MEAN_W-1:0];
                end
                default: begin
                end
            endcase
        end

        // Capture acts one cycle after the write, with the stored pair number
        if (st_q.cfg[CQM_CFG_CAPTURE_BIT]) begin
            st_d.mean_res = mean_scaled;
            st_d.slicer_res = sel_mean_raw;
            st_d.qual_res = qual_now;
            st_d.peak_res = peak_scaled;
            if (mean_scaled > st_d.mean_worst) begin
                st_d.mean_worst = mean_scaled;
            end
            if (qual_now < st_d.qual_worst) begin
                st_d.qual_worst = qual_now;
            end
            if (peak_scaled > st_d.peak_worst) begin
                st_d.peak_worst = peak_scaled;
            end
        end

        if (bus_go && !HWRITE) begin
            case (HADDR[7:0])
                CQM_OFS_CONFIG: st_d.rdata = {6'h0, st_q.cfg[25:4], 1'b0, st_q.cfg[2:0]};
                CQM_OFS_MEAN: st_d.rdata = 32'(st_q.mean_res);
                CQM_OFS_MEAN_WORST: st_d.rdata = 32'(st_q.mean_worst);
                CQM_OFS_QUALITY: st_d.rdata = 32'({st_q.qual_worst, 1'b0, st_q.qual_res});
                CQM_OFS_SLICER_MEAN: st_d.rdata = 32'(st_q.slicer_res);
                CQM_OFS_PEAK: st_d.rdata = 32'({st_q.peak_worst, 2'b00, st_q.peak_res});
                CQM_OFS_THRESH_LO: st_d.rdata = 32'(st_q.thresh[0 +: 3*CQM_MEAN_W]);
                CQM_OFS_THRESH_HI: st_d.rdata = 32'(st_q.thresh[3*CQM_MEAN_W +: 3*CQM_MEAN_W]);
                CQM_OFS_THRESH_TOP: st_d.rdata = 32'(st_q.thresh[6*CQM_MEAN_W +: CQM_MEAN_W]);
                default: st_d.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            st_q <= '0;
            st_q.qual_res <= 3'h7;
            st_q.qual_worst <= 3'h7;
        end else begin
            st_q <= st_d;
        end
    end

    assign HRDATA = st_q.rdata;
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;

endmodule
`default_nettype wire

// >>> verif/cqm_slicer_model.sv
`timescale 1ns/100ps
`default_nettype none
module cqm_slicer_model
    import cqm_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic gigabit,
    input wire logic [6:0] mag,
    output cqm_sample_s sample
);
    // ------------------------------------------------------------
    // Symbol source, one sample per cycle while running
    // ------------------------------------------------------------
    logic [7:0] lim;
    // Clamp to the largest legal slicer error of the mode
    assign lim = (gigabit && mag > 7'h20) ? 8'h20 : ((mag > 7'h40) ? 8'h40 : {1'b0, mag});
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sample <= '0;
        end else begin
            sample.valid <= run;
            sample.pair <= 2'($urandom);
            // Idle cycles carry junk so a stale error is never mistaken for data
            if (run) begin
                sample.err <= $urandom_range(1, 0) ? 8'(-lim) : lim;
            end else begin
                sample.err <= 8'($urandom);
            end
        end
    end
endmodule
`default_nettype wire

// >>> verif/cqm_top_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module cqm_top_asserts
    import cqm_pkg::*;
(
    input wire logic SYS_CLK,
    input wire logic RESET_N,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    input wire logic [31:0] HRDATA,
    input wire logic HREADYOUT,
    input wire logic HRESP,
    input wire cqm_sample_s SAMPLE
);
    // ------------------------------------------------------------
    // Bus response and read checks
    // ------------------------------------------------------------
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RESET_N);
    sequence s_rd_any;
        HSEL && HREADY && HTRANS[1] && !HWRITE;
    endsequence
    sequence s_rd(logic [7:0] ofs);
        HSEL && HREADY && HTRANS[1] && !HWRITE && HADDR[7:0] == ofs;
    endsequence
    a_resp_okay: assert property (HREADYOUT && !HRESP) else $error("bus answer not ready okay");
    a_rdata_hold: assert property (!(HSEL && HREADY && HTRANS[1] && !HWRITE) |=> $stable(HRDATA))
        else $error("read data changed without read");
    a_unmapped_zero: assert property (s_rd_any ##0 (HADDR[7:0] > 8'h20) |=> HRDATA == 32'h0)
        else $error("unmapped read not zero");
    a_config_clear: assert property (s_rd(CQM_OFS_CONFIG) |=> !HRDATA[3] && HRDATA[31:26] == 6'h0)
        else $error("capture bit reads set");
    a_mean_range: assert property (s_rd(CQM_OFS_MEAN) |=> HRDATA[31:9] == 23'h0)
        else $error("mean above range");
    a_worst_range: assert property (s_rd(CQM_OFS_MEAN_WORST) |=> HRDATA[31:9] == 23'h0)
        else $error("mean worst above range");
    a_quality_order: assert property (s_rd(CQM_OFS_QUALITY) |=> HRDATA[6:4] <= HRDATA[2:0]
        && !HRDATA[3] && HRDATA[31:7] == 25'h0) else $error("quality worst above current");
    a_peak_order: assert property (s_rd(CQM_OFS_PEAK) |=> HRDATA[13:8] >= HRDATA[5:0]
        && HRDATA[7:6] == 2'h0 && HRDATA[31:14] == 18'h0) else $error("peak worst below current");
    a_slicer_range: assert property (s_rd(CQM_OFS_SLICER_MEAN) |=> HRDATA[31:13] == 19'h0)
        else $error("slicer mean above range");
endmodule
bind cqm_top cqm_top_asserts u_asserts (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .SAMPLE(SAMPLE));
`default_nettype wire

// >>> verif/tb_channel_quality_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module tb_channel_quality_monitor
    import cqm_pkg::*;
;
    // ------------------------------------------------------------
    // Bench
    // ------------------------------------------------------------
    logic SYS_CLK = 1'b0;
    logic RESET_N = 1'b0;
    logic HSEL = 1'b0, HWRITE = 1'b0, run = 1'b0;
    logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, HRDATA, rd;
    logic [1:0] HTRANS = 2'h0;
    logic [2:0] HSIZE = 3'h2;
    logic [6:0] mag = 7'h0;
    logic gig = 1'b1;
    // Short save period keeps the run brief; the counting logic is unchanged
    localparam int T_PERIOD = 2000;
    logic HREADYOUT, HRESP;
    wire logic HREADY;
    cqm_sample_s SAMPLE;
    int mismatches = 0, total_checks = 0, e, m, pk, q;
    assign HREADY = HREADYOUT;
    always #25 SYS_CLK = ~SYS_CLK;
    cqm_top #(.SAVE_SYMBOLS(T_PERIOD)) u_dut (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .HSEL(HSEL), .HADDR(HADDR),
        .HTRANS(HTRANS),
        .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
        .HREADYOUT(HREADYOUT), .HRESP(HRESP), .SAMPLE(SAMPLE));
    cqm_slicer_model u_src (.clk(SYS_CLK), .rst_n(RESET_N), .run(run), .gigabit(gig), .mag(mag), .sample(SAMPLE));
    task end_sim;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task check(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", name, exp, got);
            mismatches++;
        end
    endtask
    // Bounded wait so a dead slave ends the run instead of hanging it
    task wait_ready;
        int n;
        n = 0;
        do begin @(posedge SYS_CLK); n++; end while (HREADYOUT !== 1'b1 && n < 20);
        if (HREADYOUT !== 1'b1) begin
            check("HREADYOUT", 32'h1, {31'h0, HREADYOUT});
            end_sim();
        end
    endtask
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge SYS_CLK);
        HSEL <= 1'b1; HTRANS <= 2'h2; HWRITE <= wr; HADDR <= {24'h0, a};
        wait_ready();
        HTRANS <= 2'h0; HWDATA <= wd;
        wait_ready();
        rd = HRDATA;
    endtask
    task rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(name, exp, rd);
    endtask
    function automatic int f_sat(int v, int mx); return (v > mx) ? mx : v; endfunction
    function automatic int f_qual(int v);
        int t[1:7] = '{447, 383, 319, 255, 0, 0, 1};
        int r = 7;
        for (int k = 7; k >= 1; k--) if (v > t[k]) r = k - 1;
        return r;
    endfunction
    task chk_pairs(input logic [31:0] c, input int em, input int ep, input int eq, input int es, input logic exact);
        for (int p = 0; p < 4; p++) begin
            bus(1'b1, CQM_OFS_CONFIG, c | 32'h8 | 32'(p << 4));
            repeat (3) @(posedge SYS_CLK);
            rd_chk("mean", CQM_OFS_MEAN, 32'(em));
            rd_chk("mean worst", CQM_OFS_MEAN_WORST, 32'(em));
            rd_chk("quality", CQM_OFS_QUALITY, 32'((eq << 4) | eq));
            if (exact) begin
                rd_chk("slicer mean", CQM_OFS_SLICER_MEAN, 32'(es));
            end else begin
                // Truncating add-back settles up to one step below the target
                bus(1'b0, CQM_OFS_SLICER_MEAN, 32'h0);
                check("slicer mean", 32'h1, {31'h0, (rd === 32'(es)) || (rd === 32'(es - 1))});
            end
            rd_chk("peak", CQM_OFS_PEAK, 32'((ep << 8) | ep));
        end
    endtask
    initial begin
        void'($urandom(32'hF2A21566));
        e = $urandom_range(16, 8);
        repeat (5) @(posedge SYS_CLK);
        RESET_N <= 1'b1;
        rd_chk("quality reset", CQM_OFS_QUALITY, 32'h77);
        rd_chk("unmapped", 8'h24, 32'h0);
        bus(1'b1, CQM_OFS_THRESH_LO, {5'h0, 9'h13F, 9'h17F, 9'h1BF});
        bus(1'b1, CQM_OFS_THRESH_HI, {23'h0, 9'h0FF});
        bus(1'b1, CQM_OFS_THRESH_TOP, 32'h1);
        rd_chk("threshold lo", CQM_OFS_THRESH_LO, {5'h0, 9'h13F, 9'h17F, 9'h1BF});
        rd_chk("threshold top", CQM_OFS_THRESH_TOP, 32'h1);
        bus(1'b1, CQM_OFS_CONFIG, 32'h7);
        @(posedge SYS_CLK);
        mag <= 7'(e);
        run <= 1'b1;
        repeat (1000) @(posedge SYS_CLK);
        bus(1'b1, CQM_OFS_CONFIG, 32'h1F);
        rd_chk("config", CQM_OFS_CONFIG, 32'h17);
        repeat (3) @(posedge SYS_CLK);
        rd_chk("mean early", CQM_OFS_MEAN, 32'h0);
        rd_chk("quality early", CQM_OFS_QUALITY, 32'h77);
        rd_chk("peak early", CQM_OFS_PEAK, 32'h0);
        repeat (T_PERIOD) @(posedge SYS_CLK);
        run <= 1'b0;
        m = f_sat(4 * e * e, 511);
        pk = f_sat((4 * e * e) >> 3, 63);
        q = f_qual(m);
        chk_pairs(32'h7, m, pk, q, 4 * e * e, 1'b1);
        // Second pass: 100 Mb/s, absolute error, nonzero shifts and scales
        bus(1'b1, CQM_OFS_CONFIG, 32'h0);
        e = 2 * $urandom_range(31, 4) + 1;
        gig <= 1'b0;
        mag <= 7'(e);
        bus(1'b1, CQM_OFS_CONFIG, 32'h0021_2301);
        run <= 1'b1;
        repeat (T_PERIOD + 500) @(posedge SYS_CLK);
        run <= 1'b0;
        bus(1'b1, CQM_OFS_CONFIG, 32'h0021_2309);
        repeat (3) @(posedge SYS_CLK);
        rd_chk("mean worst held", CQM_OFS_MEAN_WORST, 32'(m));
        bus(1'b0, CQM_OFS_MEAN, 32'h0);
        rd_chk("quality held", CQM_OFS_QUALITY, 32'((q << 4) | f_qual(f_sat(e >> 1, 511))));
        rd_chk("peak held", CQM_OFS_PEAK, 32'((pk << 8) | f_sat(e >> 4, 63)));
        chk_pairs(32'h0021_2301, f_sat(e >> 1, 511), f_sat(e >> 4, 63), f_qual(f_sat(e >> 1, 511)), e, 1'b0);
        end_sim();
    end
endmodule
`default_nettype wire
